// ### rtl/spi_if.sv
// serial command link between host and transmitter
`timescale 1ns/1ps
interface spi_if;
  logic sck;
  logic cs_n;
  logic sdi;
  modport device (input sck, input cs_n, input sdi);
  modport host (output sck, output cs_n, output sdi);
endinterface // spi_if

// ### rtl/tx_cmd_device.sv
// device end: serial command decode, channel and rate registers, keying
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - eeprom transmit word low byte counts bytes
// - processor mode sends code, then unclocked data
// - after processor transmit, serial input keys output
// - clock pulses during keying mean commands again
// - host enables amplifier before eeprom transmit
// - manual keying needs host-started oscillator first
// - transmit command starts oscillator and synthesizer
// - sender waits for settling before first bit
// - frequency word holds 12-bit channel value
// - host keeps channel between 96 and 3903
// - out-of-range channel keeps previous value
// - tuning step follows the band
// - rate word low byte is divisor
// - bit rate is 10000/(29*(divisor+1)) kbps
module tx_cmd_device (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic eeprom_mode,
  input wire logic [1:0] band,
  spi_if.device link,
  output logic keying_input,
  output logic osc_enable,
  output logic synth_enable,
  output logic tx_active,
  output logic bit_strobe,
  output logic [11:0] channel_value,
  output logic [7:0] rate_divisor,
  output logic [7:0] byte_count,
  output logic [12:0] step_hz
);
  // ==========================================
  // link domain: shift in on rising sck
  logic [3:0] bit_cnt;
  logic [15:0] shift;
  logic [15:0] word_hold;
  logic word_short, word_tgl, start_tgl;
  logic mode_l1, mode_l2;
  logic [15:0] next_shift;
  logic short_hit;

  assign next_shift = {shift[14:0], link.sdi};
  assign short_hit = (bit_cnt == 4'h7) && !mode_l2 &&
                     (next_shift[7:0] == tx_cmd_pkg::tx_code);

  // mode strap brought into the link domain
  always_ff @(posedge link.sck or negedge presetn) begin
    if (!presetn) begin
      mode_l1 <= 1'b0;
      mode_l2 <= 1'b0;
    end else begin
      mode_l1 <= eeprom_mode;
      mode_l2 <= mode_l1;
    end
  end

  // a frame boundary realigns the bit count
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt <= 4'h0;
    end else if (short_hit) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge link.sck or negedge presetn) begin
    if (!presetn) begin
      shift <= 16'h0000;
      word_hold <= 16'h0000;
      word_short <= 1'b0;
      word_tgl <= 1'b0;
      start_tgl <= 1'b0;
    end else begin
      shift <= next_shift;
      // any clocked bit after a keying command starts a new command word
      if (bit_cnt == 4'h0) begin
        start_tgl <= !start_tgl;
      end
      if (short_hit || (bit_cnt == 4'hf)) begin
        word_hold <= next_shift;
        word_short <= short_hit;
        word_tgl <= !word_tgl;
      end
    end
  end

  // ==========================================
  // crossing into pclk: two flops per bit before use
  logic [3:0] sync1, sync2;
  logic word_seen, start_seen, cs_seen;
  logic word_ev, start_ev, frame_end, mode_p, sdi_p, cs_p;
  logic [3:0] sync_in;

  assign sync_in = {eeprom_mode, link.sdi, link.cs_n, word_tgl};
  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          // the frame line idles high; resetting its copy low would fake a frame end
          sync1[i] <= (i == 1);
          sync2[i] <= (i == 1);
        end else begin
          sync1[i] <= sync_in[i];
          sync2[i] <= sync1[i];
        end
      end
    end
  endgenerate

  logic start_s1, start_s2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_s1 <= 1'b0;
      start_s2 <= 1'b0;
      word_seen <= 1'b0;
      start_seen <= 1'b0;
      cs_seen <= 1'b1;
    end else begin
      start_s1 <= start_tgl;
      start_s2 <= start_s1;
      word_seen <= sync2[0];
      start_seen <= start_s2;
      cs_seen <= sync2[1];
    end
  end

  assign word_ev = sync2[0] != word_seen;
  assign start_ev = start_s2 != start_seen;
  assign cs_p = sync2[1];
  assign frame_end = cs_p && !cs_seen;
  assign sdi_p = sync2[2];
  assign mode_p = sync2[3];

  // ==========================================
  // command decode; word_hold is stable long after its toggle arrives
  logic tx_short_cmd, tx_long_cmd, freq_cmd, rate_cmd, in_range;
  logic keying_mode, tx_done;

  assign tx_short_cmd = word_ev && word_short && !mode_p &&
                        (word_hold[7:0] == tx_cmd_pkg::tx_code);
  assign tx_long_cmd = word_ev && !word_short && mode_p &&
                       (word_hold[15:8] == tx_cmd_pkg::tx_code);
  assign freq_cmd = word_ev && !word_short &&
                    (word_hold[15:12] == tx_cmd_pkg::freq_code);
  assign rate_cmd = word_ev && !word_short && mode_p &&
                    (word_hold[15:8] == tx_cmd_pkg::rate_code);
  assign in_range = (word_hold[11:0] >= tx_cmd_pkg::channel_min) &&
                    (word_hold[11:0] <= tx_cmd_pkg::channel_max);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_value <= tx_cmd_pkg::freq_reset[11:0];
    end else if (freq_cmd && in_range) begin
      channel_value <= word_hold[11:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_divisor <= tx_cmd_pkg::rate_reset[7:0];
    end else if (rate_cmd) begin
      rate_divisor <= word_hold[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_count <= tx_cmd_pkg::tx_reset[7:0];
    end else if (tx_long_cmd) begin
      byte_count <= word_hold[7:0];
    end
  end

  // keying lasts until a clocked bit or the end of the frame; a new command wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keying_mode <= 1'b0;
    end else if (tx_short_cmd) begin
      keying_mode <= 1'b1;
    end else if (start_ev || frame_end || cs_p) begin
      keying_mode <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keying_input <= 1'b0;
    end else begin
      keying_input <= keying_mode && sdi_p;
    end
  end

  // oscillator and synthesizer come up with any transmit command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_enable <= 1'b0;
      synth_enable <= 1'b0;
    end else if (tx_short_cmd || tx_long_cmd) begin
      osc_enable <= 1'b1;
      synth_enable <= 1'b1;
    end else if (!keying_mode && !tx_active) begin
      osc_enable <= 1'b0;
      synth_enable <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_hz <= tx_cmd_pkg::step_low_hz;
    end else begin
      case (band)
        2'b10: step_hz <= tx_cmd_pkg::step_mid_hz;
        2'b11: step_hz <= tx_cmd_pkg::step_high_hz;
        default: step_hz <= tx_cmd_pkg::step_low_hz;
      endcase
    end
  end

  // ==========================================
  // eeprom-mode bit timing: rate_unit_cycles * (divisor + 1) per bit
  logic [9:0] unit_cnt;
  logic [7:0] div_cnt;
  logic [10:0] bits_left;
  logic unit_wrap, bit_wrap;

  assign unit_wrap = unit_cnt == 10'(tx_cmd_pkg::rate_unit_cycles - 1);
  assign bit_wrap = unit_wrap && (div_cnt == rate_divisor);
  assign tx_done = bit_wrap && (bits_left == 11'h001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_cnt <= 10'h000;
      div_cnt <= 8'h00;
    end else if (!tx_active || tx_long_cmd) begin
      unit_cnt <= 10'h000;
      div_cnt <= 8'h00;
    end else if (unit_wrap) begin
      unit_cnt <= 10'h000;
      div_cnt <= bit_wrap ? 8'h00 : div_cnt + 8'h01;
    end else begin
      unit_cnt <= unit_cnt + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_active <= 1'b0;
      bits_left <= 11'h000;
      bit_strobe <= 1'b0;
    end else begin
      bit_strobe <= tx_active && bit_wrap;
      if (tx_long_cmd) begin
        tx_active <= word_hold[7:0] != 8'h00;
        bits_left <= {word_hold[7:0], 3'b000};
      end else if (tx_active && bit_wrap) begin
        bits_left <= bits_left - 11'h001;
        tx_active <= !tx_done;
      end
    end
  end
endmodule // tx_cmd_device

// ### rtl/tx_cmd_host.sv
// host end: apb registers driving the serial command link
`timescale 1ns/1ps
module tx_cmd_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  spi_if.host link
);
  typedef enum logic [2:0] {
    h_idle = 3'b000, h_shift = 3'b001, h_settle = 3'b011, h_key = 3'b010, h_gap = 3'b110
  } host_state_t;
  host_state_t state;
  logic [15:0] shreg, last_word;
  logic [4:0] bits_left;
  logic [3:0] phase;
  logic [9:0] wait_cnt;
  logic short_cmd, key_after, key_level, amp_ok, amp_refused, range_refused;
  logic sck_q, cs_n_q, sdi_q;
  logic wr, rd_setup, start, release_key, mapped;
  logic [15:0] w_in;
  logic short_in, tx_in, refuse_amp, refuse_range;

  // ==========================================
  // apb slave, zero wait states
  assign pready = 1'b1;
  assign mapped = (paddr == tx_cmd_pkg::cmd_addr) || (paddr == tx_cmd_pkg::key_addr) ||
                  (paddr == tx_cmd_pkg::status_addr);
  assign pslverr = psel && penable && !mapped;
  assign wr = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign w_in = pwdata[15:0];
  assign short_in = pwdata[tx_cmd_pkg::cmd_short_pos];
  assign tx_in = short_in ? (w_in[7:0] == tx_cmd_pkg::tx_code)
                          : (w_in[15:8] == tx_cmd_pkg::tx_code);
  assign refuse_amp = tx_in && !short_in && !amp_ok;
  assign refuse_range = !short_in && (w_in[15:12] == tx_cmd_pkg::freq_code) &&
                        ((w_in[11:0] < tx_cmd_pkg::channel_min) ||
                         (w_in[11:0] > tx_cmd_pkg::channel_max));
  assign start = wr && (paddr == tx_cmd_pkg::cmd_addr) && (state == h_idle) &&
                 !refuse_amp && !refuse_range;
  assign release_key = wr && (paddr == tx_cmd_pkg::key_addr) && pwdata[tx_cmd_pkg::key_release_pos];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (paddr)
        tx_cmd_pkg::cmd_addr: prdata <= {15'h0000, short_cmd, last_word};
        tx_cmd_pkg::key_addr: prdata <= {31'h0000_0000, key_level};
        tx_cmd_pkg::status_addr: prdata <= {28'h000_0000, range_refused, amp_refused,
                                            state == h_key, state != h_idle};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // refusal flags, set on a refused command, cleared by the next accepted one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_refused <= 1'b0;
      range_refused <= 1'b0;
    end else if (wr && (paddr == tx_cmd_pkg::cmd_addr) && (state == h_idle)) begin
      amp_refused <= refuse_amp;
      range_refused <= refuse_range;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_level <= 1'b0;
    end else if (wr && (paddr == tx_cmd_pkg::key_addr)) begin
      key_level <= pwdata[0];
    end
  end

  // remember whether a power word has turned the amplifier on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_ok <= 1'b0;
    end else if (start && !short_in && (w_in[15:8] == tx_cmd_pkg::power_code)) begin
      amp_ok <= w_in[tx_cmd_pkg::amp_enable_bit] | w_in[tx_cmd_pkg::auto_amp_on_bit];
    end
  end

  // ==========================================
  // link sequencer: sck is pclk divided by 16
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= h_idle;
      shreg <= 16'h0000;
      last_word <= 16'h0000;
      bits_left <= 5'h00;
      phase <= 4'h0;
      wait_cnt <= 10'h000;
      short_cmd <= 1'b0;
      key_after <= 1'b0;
    end else begin
      case (state)
        h_idle: begin
          phase <= 4'h0;
          if (start) begin
            state <= h_shift;
            short_cmd <= short_in;
            key_after <= pwdata[tx_cmd_pkg::cmd_key_pos] && short_in && tx_in;
            last_word <= w_in;
            shreg <= short_in ? {w_in[7:0], 8'h00} : w_in;
            bits_left <= short_in ? 5'h08 : 5'h10;
          end
        end
        h_shift: begin
          phase <= phase + 4'h1;
          if (phase == 4'hf) begin
            shreg <= {shreg[14:0], 1'b0};
            bits_left <= bits_left - 5'h01;
            if (bits_left == 5'h01) begin
              wait_cnt <= 10'h000;
              state <= key_after ? h_settle : h_gap;
            end
          end
        end
        h_settle: begin
          // oscillator and synthesizer start-up before the first keyed bit
          wait_cnt <= wait_cnt + 10'h001;
          if (wait_cnt == 10'(tx_cmd_pkg::settle_cycles - 1)) begin
            state <= h_key;
          end
        end
        h_key: begin
          if (release_key) begin
            wait_cnt <= 10'h000;
            state <= h_gap;
          end
        end
        h_gap: begin
          wait_cnt <= wait_cnt + 10'h001;
          if (wait_cnt == 10'(tx_cmd_pkg::gap_cycles - 1)) begin
            state <= h_idle;
          end
        end
        default: state <= h_idle;
      endcase
    end
  end

  // pins: data changes while sck is low; keying holds sck still
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      sdi_q <= 1'b0;
    end else begin
      sck_q <= (state == h_shift) && (phase[3] != (phase == 4'hf));
      cs_n_q <= !((state == h_shift) || (state == h_settle) || (state == h_key));
      if (state == h_shift) begin
        sdi_q <= shreg[15];
      end else if (state == h_key) begin
        sdi_q <= key_level;
      end else begin
        sdi_q <= 1'b0;
      end
    end
  end

  assign link.sck = sck_q;
  assign link.cs_n = cs_n_q;
  assign link.sdi = sdi_q;
endmodule // tx_cmd_host

// ### rtl/tx_cmd_pkg.sv
// shared constants for the transmitter command link
package tx_cmd_pkg;
  // ==========================================
  // command words and reset values
  localparam logic [7:0] tx_code = 8'hc6;
  localparam logic [3:0] freq_code = 4'ha;
  localparam logic [7:0] rate_code = 8'hc8;
  localparam logic [7:0] power_code = 8'hc0;
  localparam logic [15:0] tx_reset = 16'hc600;
  localparam logic [15:0] freq_reset = 16'ha7d0;
  localparam logic [15:0] rate_reset = 16'hc800;
  localparam int amp_enable_bit = 3;
  localparam int auto_amp_on_bit = 6;
  // ==========================================
  // channel limits and tuning steps per band
  localparam logic [11:0] channel_min = 12'h060;
  localparam logic [11:0] channel_max = 12'hf3f;
  localparam logic [12:0] step_low_hz = 13'h09c4;
  localparam logic [12:0] step_mid_hz = 13'h1388;
  localparam logic [12:0] step_high_hz = 13'h1d4c;
  // ==========================================
  // timing: bit period is rate_unit_ns * (divisor + 1)
  localparam int pclk_mhz = 250;
  localparam int rate_unit_ns = 2900;
  localparam int rate_unit_cycles = rate_unit_ns * pclk_mhz / 1000;
  localparam int settle_ns = 2000;
  localparam int settle_cycles = (settle_ns * pclk_mhz + 999) / 1000;
  localparam int gap_cycles = 16;
  // ==========================================
  // host register map (apb byte addresses)
  localparam logic [7:0] cmd_addr = 8'h00;
  localparam logic [7:0] key_addr = 8'h04;
  localparam logic [7:0] status_addr = 8'h08;
  localparam int cmd_short_pos = 16;
  localparam int cmd_key_pos = 17;
  localparam int key_release_pos = 1;
endpackage

// ### sim/test_tx_command_freq_rate_regs.sv
// testbench joining host and device ends over the serial link
`timescale 1ns/1ps
module test_tx_command_freq_rate_regs;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic eeprom_mode = 1'b1;
  logic [1:0] band = 2'b00;
  logic keying_input, osc_enable, synth_enable, tx_active, bit_strobe;
  logic [11:0] channel_value;
  logic [7:0] rate_divisor, byte_count;
  logic [12:0] step_hz;
  logic [31:0] rd;
  logic er;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  // word, channel, divisor, status flags {range, amp}
  logic [37:0] rows [8] = '{{16'ha060, 12'h060, 8'h00, 2'b00}, {16'haf3f, 12'hf3f, 8'h00, 2'b00},
    {16'ha05f, 12'hf3f, 8'h00, 2'b10}, {16'haf40, 12'hf3f, 8'h00, 2'b10},
    {16'ha7d0, 12'h7d0, 8'h00, 2'b00}, {16'hc823, 12'h7d0, 8'h23, 2'b00},
    {16'hc8ff, 12'h7d0, 8'hff, 2'b00}, {16'he000, 12'h7d0, 8'hff, 2'b00}};
  spi_if link ();
  always #2 pclk = ~pclk;
  tx_cmd_host u_tx_cmd_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  tx_cmd_device u_tx_cmd_device (.pclk(pclk), .presetn(presetn), .eeprom_mode(eeprom_mode),
    .band(band), .link(link), .keying_input(keying_input), .osc_enable(osc_enable),
    .synth_enable(synth_enable), .tx_active(tx_active), .bit_strobe(bit_strobe),
    .channel_value(channel_value), .rate_divisor(rate_divisor), .byte_count(byte_count),
    .step_hz(step_hz));
  tx_cmd_chk u_tx_cmd_chk (.pclk(pclk), .presetn(presetn), .sck(link.sck), .cs_n(link.cs_n),
    .sdi(link.sdi), .band(band), .keying_input(keying_input), .osc_enable(osc_enable),
    .synth_enable(synth_enable), .tx_active(tx_active), .bit_strobe(bit_strobe),
    .channel_value(channel_value), .rate_divisor(rate_divisor), .step_hz(step_hz));
  // ==========================================
  // tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input logic [31:0] w);
    apb(1'b1, tx_cmd_pkg::cmd_addr, w);
    repeat (4) @(posedge pclk);
    do apb(1'b0, tx_cmd_pkg::status_addr, 32'h0); while (rd[0] !== 1'b0);
    repeat (10) @(posedge pclk);
  endtask
  // ==========================================
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      close_out();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("channel reset", {20'h0, channel_value}, 32'h7d0);
    chk("rate reset", {24'h0, rate_divisor}, 32'h0);
    chk("count reset", {24'h0, byte_count}, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      send({16'h0, rows[i][37:22]});
      chk("flags", {30'h0, rd[3:2]}, {30'h0, rows[i][1:0]});
      chk("channel", {20'h0, channel_value}, {20'h0, rows[i][21:10]});
      chk("divisor", {24'h0, rate_divisor}, {24'h0, rows[i][9:2]});
    end
    for (int b = 0; b < 4; b++) begin
      band <= 2'(b);
      repeat (3) @(posedge pclk);
      chk("step", {19'h0, step_hz}, b > 2 ? 32'h1d4c : b > 1 ? 32'h1388 : 32'h9c4);
    end
    // transmit refused until the amplifier is enabled
    send(32'hc603);
    chk("amp refused", {31'h0, rd[2]}, 32'h1);
    chk("no transmit", {31'h0, tx_active}, 32'h0);
    send(32'hc008);
    send(32'hc801);
    send(32'hc601);
    chk("count", {24'h0, byte_count}, 32'h1);
    chk("osc synth", {30'h0, osc_enable, synth_enable}, 32'h3);
    n = 0;
    repeat (16 * tx_cmd_pkg::rate_unit_cycles + 64) begin
      @(posedge pclk);
      if (bit_strobe === 1'b1) n++;
    end
    chk("bits sent", n, 32'h8);
    chk("transmit done", {31'h0, tx_active}, 32'h0);
    chk("osc idle", {31'h0, osc_enable}, 32'h0);
    // processor mode: a dummy word carries the mode change over the link clock
    eeprom_mode <= 1'b0;
    send(32'he000);
    send(32'hc855);
    chk("rate ignored", {24'h0, rate_divisor}, 32'h1);
    send(32'hc030);
    apb(1'b1, tx_cmd_pkg::cmd_addr, 32'h300c6);
    repeat (700) @(posedge pclk);
    apb(1'b0, tx_cmd_pkg::status_addr, 32'h0);
    chk("keying mode", {31'h0, rd[1]}, 32'h1);
    chk("osc keying", {31'h0, osc_enable}, 32'h1);
    for (int v = 1; v >= 0; v--) begin
      apb(1'b1, tx_cmd_pkg::key_addr, 32'(v));
      repeat (10) @(posedge pclk);
      chk("keying level", {31'h0, keying_input}, 32'(v));
    end
    apb(1'b1, tx_cmd_pkg::key_addr, 32'h2);
    repeat (20) @(posedge pclk);
    apb(1'b0, tx_cmd_pkg::status_addr, 32'h0);
    chk("keying ended", {31'h0, rd[1]}, 32'h0);
    close_out();
  end
endmodule // test_tx_command_freq_rate_regs

// ### sim/tx_cmd_chk.sv
// checker for the serial command link and the device outputs
`timescale 1ns/1ps
module tx_cmd_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic [1:0] band,
  input wire logic keying_input,
  input wire logic osc_enable,
  input wire logic synth_enable,
  input wire logic tx_active,
  input wire logic bit_strobe,
  input wire logic [11:0] channel_value,
  input wire logic [7:0] rate_divisor,
  input wire logic [12:0] step_hz
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // cycles since the last bit strobe of a transmission
  logic [17:0] gap;
  logic seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap <= '0;
    else if (bit_strobe) gap <= 18'h00001;
    else gap <= gap + 18'h00001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen <= 1'b0;
    else if (bit_strobe) seen <= tx_active;
    else if (!tx_active) seen <= 1'b0;
  end
  // ==========================================
  // assertions
  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("link clock moved outside a frame");
  AST_CHAN_RANGE: assert property (channel_value >= 12'h060 && channel_value <= 12'hf3f)
    else $error("channel value outside its range");
  AST_HOLD_IDLE: assert property (cs_n [*8] |-> $stable(channel_value) && $stable(rate_divisor))
    else $error("register changed without a frame");
  AST_STEP_BAND: assert property (step_hz == ($past(band) == 2'b11 ? 13'h1d4c :
    $past(band) == 2'b10 ? 13'h1388 : 13'h09c4)) else $error("tuning step does not fit band");
  AST_KEY_IDLE: assert property (cs_n [*5] |-> !keying_input)
    else $error("keying active outside a frame");
  AST_KEY_FOLLOWS: assert property (keying_input |-> $past(sdi, 3))
    else $error("keying output not from serial input");
  AST_SCK_ENDS_KEY: assert property ($rose(sck) |-> ##[1:6] !keying_input)
    else $error("keying went on after a clock pulse");
  AST_STROBE_IN_TX: assert property (bit_strobe |-> $past(tx_active))
    else $error("bit strobe outside a transmission");
  AST_BIT_PERIOD: assert property (bit_strobe && seen |->
    gap == 725 * (int'(rate_divisor) + 1)) else $error("bit period wrong");
  AST_OSC_ON_TX: assert property (tx_active |-> ##[0:2] (osc_enable && synth_enable))
    else $error("oscillator off while transmitting");
  cover property ($rose(tx_active));
  cover property ($rose(keying_input));
  cover property (bit_strobe && seen);
  cover property ($changed(channel_value));
endmodule // tx_cmd_chk
